// ===== design/macr_pkg.sv
// Overview of operation
// - speed pin glitch filter, four codes
// - tach angle interpolation enable bit
// - quick startup speed detect enable bit
// - stopped declared after selected persistence
// - running declared after selected persistence
// - speed detect abandoned after selected timeout
// - handoff minimum back-emf from code
// - rotor position detect current limit
// - rotor position detect repeat count
// - open loop current one to eight
// - open loop speed percent of maximum
// - open loop ramp rate from code
// - reverse deceleration ratio from code
package macr_pkg;

  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned CLK_MHZ    = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [11:0] CFG_OFFSET = 12'h0A0;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

  localparam int unsigned TACH_INTERP_BIT = 29;
  localparam int unsigned GLITCH_LSB      = 27;
  localparam int unsigned QUICK_ISD_BIT   = 26;
  localparam int unsigned STOP_SEL_LSB    = 24;
  localparam int unsigned RUN_SEL_LSB     = 22;
  localparam int unsigned TMO_SEL_LSB     = 20;
  localparam int unsigned BEMF_SEL_LSB    = 17;
  localparam int unsigned ILIM_SEL_LSB    = 13;
  localparam int unsigned REPEAT_SEL_LSB  = 11;
  localparam int unsigned OLCUR_SEL_LSB   = 8;
  localparam int unsigned OLSPD_SEL_LSB   = 6;
  localparam int unsigned RAMP_SEL_LSB    = 3;
  localparam int unsigned DECEL_SEL_LSB   = 0;

  localparam int unsigned GLITCH_W    = 7;
  localparam int unsigned GLITCH_NS_1 = 200;
  localparam int unsigned GLITCH_NS_2 = 500;
  localparam int unsigned GLITCH_NS_3 = 1000;
  localparam logic [6:0]  GLITCH_CYC_1 = 7'(GLITCH_NS_1 * CLK_MHZ / 1000);
  localparam logic [6:0]  GLITCH_CYC_2 = 7'(GLITCH_NS_2 * CLK_MHZ / 1000);
  localparam logic [6:0]  GLITCH_CYC_3 = 7'(GLITCH_NS_3 * CLK_MHZ / 1000);

  localparam int unsigned PERSIST_MS_0 = 1;
  localparam int unsigned PERSIST_MS_1 = 5;
  localparam int unsigned PERSIST_MS_2 = 50;
  localparam int unsigned PERSIST_MS_3 = 100;
  localparam int unsigned TIMEOUT_MS_0 = 500;
  localparam int unsigned TIMEOUT_MS_1 = 750;
  localparam int unsigned TIMEOUT_MS_2 = 1000;
  localparam int unsigned TIMEOUT_MS_3 = 2000;

  localparam logic [10:0] BEMF_MV [8] = '{11'h000, 11'h032, 11'h064, 11'h0FA,
                                          11'h1F4, 11'h3E8, 11'h4E2, 11'h5DC};
  localparam logic [11:0] ILIM_MA [4] = '{12'h064, 12'h1F4, 12'h3E8, 12'h7D0};
  localparam logic [5:0]  OLSPD_PCT [4] = '{6'h0F, 6'h19, 6'h23, 6'h32};
  localparam logic [11:0] RAMP_CHZ [8] = '{12'h00A, 12'h032, 12'h064, 12'h0C8,
                                           12'h12C, 12'h1F4, 12'h3E8, 12'h7D0};
  localparam logic [7:0]  DECEL_PCT [8] = '{8'h32, 8'h3C, 8'h46, 8'h50,
                                            8'h5A, 8'h64, 8'h7D, 8'h96};
  localparam logic [3:0]  ONE_4 = 4'h1;

  typedef struct packed {
    logic        tach_angle_interp_enable;
    logic        quick_startup_speed_detect_enable;
    logic [10:0] handoff_min_backemf_mv;
    logic [11:0] measure_align_current_limit_ma;
    logic [3:0]  measure_align_repeat_count;
    logic [3:0]  measure_openloop_current_a;
    logic [5:0]  measure_openloop_speed_pct;
    logic [11:0] measure_openloop_ramp_chz;
    logic [7:0]  reverse_openloop_decel_ratio_pct;
  } macr_cfg_t;

endpackage

// ===== design/macr_glitch_filt.sv
`timescale 1ns/1ps
module macr_glitch_filt import macr_pkg::*; (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_pin,
  input  wire logic                i_bypass,
  input  wire logic [GLITCH_W-1:0] i_reject_cyc,
  output logic                     o_level
);

  logic                sync1_q;
  logic                sync2_q;
  logic [GLITCH_W-1:0] cnt_q;
  logic                level_q;

  // two-stage synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // level changes only after reject count plus one stable cycles
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else if (i_bypass) begin
      cnt_q   <= '0;
      level_q <= sync2_q;
    end else if (sync2_q == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= i_reject_cyc) begin
      cnt_q   <= '0;
      level_q <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign o_level = level_q;

endmodule // macr_glitch_filt

// ===== design/macr_top.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
module macr_top import macr_pkg::*; #(
  parameter int unsigned CNT_W           = 28,
  parameter int unsigned P_CYC_PER_MS    = CYC_PER_MS,
  parameter int unsigned P_PERSIST_CYC_0 = PERSIST_MS_0 * P_CYC_PER_MS,
  parameter int unsigned P_PERSIST_CYC_1 = PERSIST_MS_1 * P_CYC_PER_MS,
  parameter int unsigned P_PERSIST_CYC_2 = PERSIST_MS_2 * P_CYC_PER_MS,
  parameter int unsigned P_PERSIST_CYC_3 = PERSIST_MS_3 * P_CYC_PER_MS,
  parameter int unsigned P_TIMEOUT_CYC_0 = TIMEOUT_MS_0 * P_CYC_PER_MS,
  parameter int unsigned P_TIMEOUT_CYC_1 = TIMEOUT_MS_1 * P_CYC_PER_MS,
  parameter int unsigned P_TIMEOUT_CYC_2 = TIMEOUT_MS_2 * P_CYC_PER_MS,
  parameter int unsigned P_TIMEOUT_CYC_3 = TIMEOUT_MS_3 * P_CYC_PER_MS
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [APB_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  input  wire logic                  i_speed_pin,
  input  wire logic                  i_stop_cond,
  input  wire logic                  i_run_cond,
  input  wire logic                  i_detect_active,
  output logic                       o_speed_cmd,
  output logic                       o_motor_stopped,
  output logic                       o_motor_running,
  output logic                       o_detect_timeout,
  output macr_cfg_t                  o_cfg
);

  logic [31:0]     internal_algorithm_config_one_q;
  logic [31:0]     prdata_q;
  logic            addr_hit;
  logic            setup_ph;
  logic            access_ph;
  logic            wr_en;
  macr_cfg_t       cfg_d;
  macr_cfg_t       cfg_q;
  logic [1:0]      glitch_sel;
  logic            glitch_bypass;
  logic [6:0]      glitch_cyc;
  logic [1:0]      stop_sel;
  logic [1:0]      run_sel;
  logic [1:0]      tmo_sel;
  logic [2:0]      bemf_sel;
  logic [1:0]      ilim_sel;
  logic [1:0]      repeat_sel;
  logic [2:0]      olcur_sel;
  logic [1:0]      olspd_sel;
  logic [2:0]      ramp_sel;
  logic [2:0]      decel_sel;
  logic [CNT_W-1:0] per_lim [2];
  logic            per_cond [2];
  logic            per_flag [2];
  logic [CNT_W-1:0] tmo_lim;
  logic [CNT_W-1:0] tmo_cnt_q;
  logic            tmo_q;

  // apb decode
  assign setup_ph  = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  assign addr_hit  = (i_paddr[APB_ADDR_W-1:2] == CFG_OFFSET[APB_ADDR_W-1:2]);
  assign wr_en     = access_ph & i_pwrite & addr_hit;
  assign o_pready  = 1'b1;
  assign o_pslverr = access_ph & ~addr_hit;

  // register write with byte strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      internal_algorithm_config_one_q <= CFG_RESET;
    end else if (wr_en) begin
      for (int b = 0; b < 4; b++) begin
        if (i_pstrb[b]) begin
          internal_algorithm_config_one_q[8*b +: 8] <= i_pwdata[8*b +: 8];
        end
      end
    end
  end

  // read data captured in setup phase
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      if (addr_hit && !i_pwrite) begin
        prdata_q <= internal_algorithm_config_one_q;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign o_prdata = prdata_q;

  // field extraction
  assign glitch_sel = internal_algorithm_config_one_q[GLITCH_LSB +: 2];
  assign stop_sel   = internal_algorithm_config_one_q[STOP_SEL_LSB +: 2];
  assign run_sel    = internal_algorithm_config_one_q[RUN_SEL_LSB +: 2];
  assign tmo_sel    = internal_algorithm_config_one_q[TMO_SEL_LSB +: 2];
  assign bemf_sel   = internal_algorithm_config_one_q[BEMF_SEL_LSB +: 3];
  assign ilim_sel   = internal_algorithm_config_one_q[ILIM_SEL_LSB +: 2];
  assign repeat_sel = internal_algorithm_config_one_q[REPEAT_SEL_LSB +: 2];
  assign olcur_sel  = internal_algorithm_config_one_q[OLCUR_SEL_LSB +: 3];
  assign olspd_sel  = internal_algorithm_config_one_q[OLSPD_SEL_LSB +: 2];
  assign ramp_sel   = internal_algorithm_config_one_q[RAMP_SEL_LSB +: 3];
  assign decel_sel  = internal_algorithm_config_one_q[DECEL_SEL_LSB +: 3];

  // glitch reject length per code
  always_comb begin
    glitch_bypass = 1'b0;
    unique case (glitch_sel)
      2'h0: begin
        glitch_bypass = 1'b1;
        glitch_cyc    = 7'h00;
      end
      2'h1: glitch_cyc = GLITCH_CYC_1;
      2'h2: glitch_cyc = GLITCH_CYC_2;
      2'h3: glitch_cyc = GLITCH_CYC_3;
    endcase
  end

  macr_glitch_filt u_glitch (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_pin        (i_speed_pin),
    .i_bypass     (glitch_bypass),
    .i_reject_cyc (glitch_cyc),
    .o_level      (o_speed_cmd)
  );

  // persistence limits
  always_comb begin
    unique case (stop_sel)
      2'h0: per_lim[0] = CNT_W'(P_PERSIST_CYC_0);
      2'h1: per_lim[0] = CNT_W'(P_PERSIST_CYC_1);
      2'h2: per_lim[0] = CNT_W'(P_PERSIST_CYC_2);
      2'h3: per_lim[0] = CNT_W'(P_PERSIST_CYC_3);
    endcase
    unique case (run_sel)
      2'h0: per_lim[1] = CNT_W'(P_PERSIST_CYC_0);
      2'h1: per_lim[1] = CNT_W'(P_PERSIST_CYC_1);
      2'h2: per_lim[1] = CNT_W'(P_PERSIST_CYC_2);
      2'h3: per_lim[1] = CNT_W'(P_PERSIST_CYC_3);
    endcase
  end

  assign per_cond[0] = i_stop_cond;
  assign per_cond[1] = i_run_cond;

  // persistence counters, stopped and running
  for (genvar g = 0; g < 2; g++) begin : g_persist
    logic [CNT_W-1:0] cnt_q;
    logic             flag_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cnt_q  <= '0;
        flag_q <= 1'b0;
      end else if (!per_cond[g]) begin
        cnt_q  <= '0;
        flag_q <= 1'b0;
      end else if (!flag_q) begin
        if (cnt_q >= per_lim[g] - 1'b1) begin
          flag_q <= 1'b1;
          cnt_q  <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
    assign per_flag[g] = flag_q;
  end

  assign o_motor_stopped = per_flag[0];
  assign o_motor_running = per_flag[1];

  // detection timeout limit
  always_comb begin
    unique case (tmo_sel)
      2'h0: tmo_lim = CNT_W'(P_TIMEOUT_CYC_0);
      2'h1: tmo_lim = CNT_W'(P_TIMEOUT_CYC_1);
      2'h2: tmo_lim = CNT_W'(P_TIMEOUT_CYC_2);
      2'h3: tmo_lim = CNT_W'(P_TIMEOUT_CYC_3);
    endcase
  end

  // timeout counter, held until detection drops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmo_cnt_q <= '0;
      tmo_q     <= 1'b0;
    end else if (!i_detect_active) begin
      tmo_cnt_q <= '0;
      tmo_q     <= 1'b0;
    end else if (!tmo_q) begin
      if (tmo_cnt_q >= tmo_lim - 1'b1) begin
        tmo_q     <= 1'b1;
        tmo_cnt_q <= '0;
      end else begin
        tmo_cnt_q <= tmo_cnt_q + 1'b1;
      end
    end
  end

  assign o_detect_timeout = tmo_q;

  // decoded settings
  always_comb begin
    cfg_d = '0;
    cfg_d.tach_angle_interp_enable =
      internal_algorithm_config_one_q[TACH_INTERP_BIT];
    cfg_d.quick_startup_speed_detect_enable =
      internal_algorithm_config_one_q[QUICK_ISD_BIT];
    cfg_d.handoff_min_backemf_mv         = BEMF_MV[bemf_sel];
    cfg_d.measure_align_current_limit_ma = ILIM_MA[ilim_sel];
    cfg_d.measure_align_repeat_count     = ONE_4 << repeat_sel;
    cfg_d.measure_openloop_current_a     = {1'b0, olcur_sel} + ONE_4;
    cfg_d.measure_openloop_speed_pct     = OLSPD_PCT[olspd_sel];
    cfg_d.measure_openloop_ramp_chz      = RAMP_CHZ[ramp_sel];
    cfg_d.reverse_openloop_decel_ratio_pct = DECEL_PCT[decel_sel];
  end

  // registered settings output
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= '0;
      cfg_q.handoff_min_backemf_mv           <= BEMF_MV[0];
      cfg_q.measure_align_current_limit_ma   <= ILIM_MA[0];
      cfg_q.measure_align_repeat_count       <= ONE_4;
      cfg_q.measure_openloop_current_a       <= ONE_4;
      cfg_q.measure_openloop_speed_pct       <= OLSPD_PCT[0];
      cfg_q.measure_openloop_ramp_chz        <= RAMP_CHZ[0];
      cfg_q.reverse_openloop_decel_ratio_pct <= DECEL_PCT[0];
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign o_cfg = cfg_q;

endmodule // macr_top

// ===== verification/macr_properties.sv
`timescale 1ns/1ps
module macr_checker import macr_pkg::*; (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        i_speed_pin,
  input wire logic        i_stop_cond,
  input wire logic        i_run_cond,
  input wire logic        i_detect_active,
  input wire logic        o_speed_cmd,
  input wire logic        o_motor_stopped,
  input wire logic        o_motor_running,
  input wire logic        o_detect_timeout,
  input wire macr_cfg_t   o_cfg
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic hit;
  assign hit = i_paddr[11:2] == CFG_OFFSET[11:2];
  sequence s_wr_hit;
    i_psel && i_penable && i_pwrite && o_pready && hit && i_pstrb == 4'hF;
  endsequence
  sequence s_settle;
    s_wr_hit ##2 1'b1;
  endsequence
  property p_tach;
    s_wr_hit |=> ##1 o_cfg.tach_angle_interp_enable == $past(i_pwdata[29], 2);
  endproperty
  property p_quick;
    s_settle |-> o_cfg.quick_startup_speed_detect_enable == $past(i_pwdata[26], 2);
  endproperty
  property p_ilim;
    s_settle |-> o_cfg.measure_align_current_limit_ma == ILIM_MA[$past(i_pwdata[14:13], 2)];
  endproperty
  property p_decel;
    s_settle |-> o_cfg.reverse_openloop_decel_ratio_pct == DECEL_PCT[$past(i_pwdata[2:0], 2)];
  endproperty
  property p_err;
    i_psel && i_penable && !hit |-> o_pslverr;
  endproperty
  property p_rdmiss;
    i_psel && !i_penable && !i_pwrite && !hit |=> o_prdata == 32'h0000_0000;
  endproperty
  property p_stop;
    !i_stop_cond |=> !o_motor_stopped;
  endproperty
  property p_run;
    $rose(o_motor_running) |-> $past(i_run_cond) && $past(i_run_cond, 8);
  endproperty
  property p_tmo;
    !i_detect_active |=> !o_detect_timeout;
  endproperty
  property p_speed;
    $changed(o_speed_cmd) |-> o_speed_cmd == $past(i_speed_pin, 3);
  endproperty
  a_tach: assert property (p_tach) else $error("tach enable not from write");
  a_quick: assert property (p_quick) else $error("quick detect not from write");
  a_ilim: assert property (p_ilim) else $error("current limit wrong");
  a_decel: assert property (p_decel) else $error("decel ratio wrong");
  a_err: assert property (p_err) else $error("no error on unmapped access");
  a_rdmiss: assert property (p_rdmiss) else $error("unmapped read not zero");
  a_stop: assert property (p_stop) else $error("stopped flag held");
  a_run: assert property (p_run) else $error("running flag too early");
  a_tmo: assert property (p_tmo) else $error("timeout flag held");
  a_speed: assert property (p_speed) else $error("speed level not from pin");
endmodule // macr_checker

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import macr_pkg::*; ;
  logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_speed_pin = 1'b0, i_stop_cond = 1'b0;
  logic        i_run_cond = 1'b0, i_detect_active = 1'b0, e;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, q;
  logic [3:0]  i_pstrb = 4'hF;
  logic        o_pready, o_pslverr, o_speed_cmd, o_motor_stopped, o_motor_running;
  logic        o_detect_timeout;
  logic [31:0] o_prdata;
  macr_cfg_t   o_cfg;
  int          n_mismatch = 0, n_checks = 0;
  localparam int unsigned CPM = 8;
  always #5 i_sys_clk = ~i_sys_clk;
  macr_top #(.P_CYC_PER_MS(CPM)) macr_top_i (.*);
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    summarize();
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    if (k >= 50) timeout();
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  function automatic macr_cfg_t exp_cfg(input logic [31:0] w);
    macr_cfg_t x;
    x.tach_angle_interp_enable          = w[29];
    x.quick_startup_speed_detect_enable = w[26];
    x.handoff_min_backemf_mv            = BEMF_MV[w[19:17]];
    x.measure_align_current_limit_ma    = ILIM_MA[w[14:13]];
    x.measure_align_repeat_count        = ONE_4 << w[12:11];
    x.measure_openloop_current_a        = {1'b0, w[10:8]} + ONE_4;
    x.measure_openloop_speed_pct        = OLSPD_PCT[w[7:6]];
    x.measure_openloop_ramp_chz         = RAMP_CHZ[w[5:3]];
    x.reverse_openloop_decel_ratio_pct  = DECEL_PCT[w[2:0]];
    return x;
  endfunction
  task automatic t_reset();
    apb(1'b0, CFG_OFFSET, 32'h0000_0000);
    chk(q & 32'hBFFF_FFFF, 32'h0000_0000);
    chk(o_cfg, exp_cfg(32'h0000_0000));
  endtask
  task automatic t_fields();
    logic [2:0]  c;
    logic [31:0] w;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      w = {c[0], c[2], c[0], c[1:0], c[1], c[1:0], c[1:0], c[1:0], c, c[1:0], c[1:0],
           c[1:0], c, c[1:0], c, c};
      apb(1'b1, CFG_OFFSET, w);
      apb(1'b0, CFG_OFFSET, 32'h0000_0000);
      chk(q, w);
      chk(o_cfg, exp_cfg(w));
    end
  endtask
  task automatic t_unmapped();
    apb(1'b1, 12'h0A4, 32'h0000_0000);
    chk(e, 1'b1);
    apb(1'b0, 12'h0A4, 32'h0000_0000);
    chk({e, q}, {1'b1, 32'h0000_0000});
    apb(1'b0, CFG_OFFSET, 32'h0000_0000);
    chk({e, q}, {1'b0, 32'hFFFF_FFFF});
    i_pstrb <= 4'h5;
    apb(1'b1, CFG_OFFSET, 32'h0000_0000);
    i_pstrb <= 4'hF;
    apb(1'b0, CFG_OFFSET, 32'h0000_0000);
    chk(q, 32'hFF00_FF00);
  endtask
  task automatic t_persist();
    int ks, kr, kt;
    int pms [4] = '{PERSIST_MS_0, PERSIST_MS_1, PERSIST_MS_2, PERSIST_MS_3};
    int tms [4] = '{TIMEOUT_MS_0, TIMEOUT_MS_1, TIMEOUT_MS_2, TIMEOUT_MS_3};
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, CFG_OFFSET, (32'(c) << 24) | (32'(c) << 22) | (32'(c) << 20));
      ks = 0;
      kr = 0;
      kt = 0;
      i_stop_cond <= 1'b1;
      i_run_cond <= 1'b1;
      i_detect_active <= 1'b1;
      for (int k = 1; k <= 16100 && kt == 0; k++) begin
        @(posedge i_sys_clk);
        #1;
        if (o_motor_stopped === 1'b1 && ks == 0) ks = k;
        if (o_motor_running === 1'b1 && kr == 0) kr = k;
        if (o_detect_timeout === 1'b1 && kt == 0) kt = k;
      end
      chk(ks, pms[c] * CPM);
      chk(kr, pms[c] * CPM);
      chk(kt, tms[c] * CPM);
      @(posedge i_sys_clk);
      i_stop_cond <= 1'b0;
      i_run_cond <= 1'b0;
      i_detect_active <= 1'b0;
      @(posedge i_sys_clk);
      #1;
      chk({o_motor_stopped, o_motor_running, o_detect_timeout}, 0);
      @(posedge i_sys_clk);
    end
  endtask
  task automatic t_glitch();
    int r, h, k;
    for (int c = 0; c < 4; c++) begin
      r = (c == 0) ? 0 : (c == 1) ? 20 : (c == 2) ? 50 : 100;
      apb(1'b1, CFG_OFFSET, 32'(c) << 27);
      h = 0;
      if (r > 0) begin
        i_speed_pin <= 1'b1;
        repeat (r) @(posedge i_sys_clk);
        i_speed_pin <= 1'b0;
        repeat (r + 8) begin
          @(posedge i_sys_clk);
          #1;
          if (o_speed_cmd !== 1'b0) h++;
        end
        @(posedge i_sys_clk);
      end
      chk(h, 0);
      i_speed_pin <= 1'b1;
      k = 0;
      do begin
        @(posedge i_sys_clk);
        #1;
        k++;
      end while (o_speed_cmd !== 1'b1 && k < 300);
      if (k >= 300) timeout();
      chk(k >= r + 3 && k <= r + 4, 1);
      @(posedge i_sys_clk);
      i_speed_pin <= 1'b0;
      repeat (r + 8) @(posedge i_sys_clk);
      #1;
      chk(o_speed_cmd, 0);
      @(posedge i_sys_clk);
    end
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reset();
    t_fields();
    t_unmapped();
    t_persist();
    t_glitch();
    summarize();
  end
endmodule // tb_top
bind macr_top macr_checker macr_checker_i (.*);
